// ---- verilog/wdr_pkg.sv ----
// Constants, field layout and types of the watchdog and reset-cause block.
// Assumes one 200 MHz system clock and a plain strobe register port.

package wdr_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFS_RESET_CAUSE = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h1;

  localparam int FLD_POWERON = 0;
  localparam int FLD_PIN = 1;
  localparam int FLD_BROWNOUT = 2;
  localparam int FLD_DOG = 3;

  localparam int FLD_SEL_LO = 0;
  localparam int FLD_SEL_HI = 2;
  localparam int FLD_ENABLE = 3;
  localparam int FLD_CHANGE = 4;

  localparam logic [3:0] RST_CAUSE = 4'h1;
  localparam logic [2:0] RST_SEL = 3'h0;
  localparam logic RST_ENABLE = 1'b0;

  // ---------------------------------------------------------------
  // Safety levels
  // ---------------------------------------------------------------
  localparam logic [1:0] LEVEL0 = 2'h0;
  localparam logic [1:0] LEVEL1 = 2'h1;
  localparam logic [1:0] LEVEL2 = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int PERIOD_BASE_CYC = 16384;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STARTUP_DELAY_US = 65;
  localparam int STARTUP_CYC = STARTUP_DELAY_US * 1000000 / CLK_PERIOD_PS;
  localparam logic [2:0] CE_WINDOW_CYC = 3'h4;

  typedef enum logic {st_run, st_hold} wdr_state_t;

endpackage : wdr_pkg

// ---- verilog/wdr_watchdog.sv ----
// Watchdog timer with reset-cause flags and fuse-selected safety levels.
// Assumes the watchdog oscillator, pin and brown-out levels and fuses are
// asynchronous to i_mclk; kick and register strobes are i_mclk-synchronous.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module wdr_watchdog #(
  parameter int PERIOD_BASE = wdr_pkg::PERIOD_BASE_CYC,
  parameter int STARTUP_CYCLES = wdr_pkg::STARTUP_CYC
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_wdt_osc,
  input wire logic i_kick,
  input wire logic i_pin_reset,
  input wire logic i_brownout,
  input wire logic i_compat_fuse_n,
  input wire logic i_always_on_fuse_n,
  input wire logic [wdr_pkg::ADDR_W-1:0] i_addr,
  input wire logic [wdr_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [wdr_pkg::DATA_W-1:0] o_rdata,
  output logic o_chip_reset,
  output logic o_startup_hold
);

  localparam int HOLD_W = $clog2(STARTUP_CYCLES + 1);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic osc_prev_reg;
  logic pin_prev_reg;
  logic brown_prev_reg;
  logic osc_tick;
  logic pin_rise;
  logic brown_rise;

  logic [1:0] level_reg;
  logic [1:0] level_next;
  logic en_reg;
  logic en_next;
  logic [2:0] sel_reg;
  logic [2:0] sel_next;
  logic [2:0] ce_cnt_reg;
  logic [2:0] ce_cnt_next;
  logic ce_active;
  logic en_eff;
  logic ctrl_wr;
  logic cause_wr;

  logic [20:0] cnt_reg;
  logic [20:0] cnt_next;
  logic timeout;
  logic chip_event;
  logic [21:0] period;
  wdr_pkg::wdr_state_t state_reg;
  wdr_pkg::wdr_state_t state_next;
  logic [HOLD_W-1:0] hold_cnt_reg;
  logic [HOLD_W-1:0] hold_cnt_next;
  logic hold_next;
  logic pulse_next;

  logic [3:0] cause_reg;
  logic [3:0] cause_next;
  logic [7:0] rdata_next;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [21:0] period_of(input logic [2:0] sel);
    period_of = 22'(PERIOD_BASE) << sel;
  endfunction : period_of

  function automatic logic [1:0] level_of(input logic compat_n, input logic always_n);
    if (!always_n) begin
      level_of = wdr_pkg::LEVEL2;
    end else if (!compat_n) begin
      level_of = wdr_pkg::LEVEL0;
    end else begin
      level_of = wdr_pkg::LEVEL1;
    end
  endfunction : level_of

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // First stage feeds only the second; edges are taken after stage two
  always_ff @(posedge i_mclk) begin
    sync1_reg <= {i_always_on_fuse_n, i_compat_fuse_n, i_brownout, i_pin_reset, i_wdt_osc};
    sync2_reg <= sync1_reg;
  end

  // Prev levels reset high so a level already up at release is no event
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      osc_prev_reg <= 1'b1;
      pin_prev_reg <= 1'b1;
      brown_prev_reg <= 1'b1;
    end else begin
      osc_prev_reg <= sync2_reg[0];
      pin_prev_reg <= sync2_reg[1];
      brown_prev_reg <= sync2_reg[2];
    end
  end

  assign osc_tick = sync2_reg[0] & ~osc_prev_reg;
  assign pin_rise = sync2_reg[1] & ~pin_prev_reg;
  assign brown_rise = sync2_reg[2] & ~brown_prev_reg;

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  assign ctrl_wr = i_wr && (i_addr == wdr_pkg::OFS_CONTROL);
  assign cause_wr = i_wr && (i_addr == wdr_pkg::OFS_RESET_CAUSE);
  assign ce_active = (ce_cnt_reg != 3'h0);
  assign en_eff = en_reg | (level_reg == wdr_pkg::LEVEL2);
  assign chip_event = timeout | pin_rise | brown_rise;

  always_comb begin
    level_next = level_of(sync2_reg[3], sync2_reg[4]);
    en_next = en_reg;
    sel_next = sel_reg;
    ce_cnt_next = ce_active ? ce_cnt_reg - 3'h1 : 3'h0;
    if (chip_event) begin
      // A chip reset returns the control register to its reset state
      en_next = wdr_pkg::RST_ENABLE;
      sel_next = wdr_pkg::RST_SEL;
      ce_cnt_next = 3'h0;
    end else if (ctrl_wr) begin
      if (i_wdata[wdr_pkg::FLD_ENABLE]) begin
        en_next = 1'b1;
      end else if (ce_active) begin
        en_next = 1'b0;
      end
      if ((level_reg == wdr_pkg::LEVEL0) || ce_active) begin
        sel_next = i_wdata[wdr_pkg::FLD_SEL_HI:wdr_pkg::FLD_SEL_LO];
      end
      // Writing change-enable high reopens the window; low closes it
      ce_cnt_next = i_wdata[wdr_pkg::FLD_CHANGE] ? wdr_pkg::CE_WINDOW_CYC : 3'h0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      level_reg <= wdr_pkg::LEVEL1;
      en_reg <= wdr_pkg::RST_ENABLE;
      sel_reg <= wdr_pkg::RST_SEL;
      ce_cnt_reg <= 3'h0;
    end else begin
      level_reg <= level_next;
      en_reg <= en_next;
      sel_reg <= sel_next;
      ce_cnt_reg <= ce_cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // Watchdog counter and reset pulse
  // ---------------------------------------------------------------
  assign period = period_of(sel_reg);
  // Kick wins over an expiry in the same cycle
  assign timeout = en_eff && osc_tick && !i_kick && !o_startup_hold &&
                   ({1'b0, cnt_reg} == period - 22'h1);

  always_comb begin
    cnt_next = cnt_reg;
    pulse_next = timeout;
    state_next = state_reg;
    hold_cnt_next = hold_cnt_reg;
    if (!en_eff || i_kick || o_startup_hold || chip_event) begin
      cnt_next = 21'h0;
    end else if (osc_tick) begin
      cnt_next = cnt_reg + 21'h1;
    end
    case (state_reg)
      wdr_pkg::st_run: begin
        if (o_chip_reset) begin
          state_next = wdr_pkg::st_hold;
          hold_cnt_next = HOLD_W'(STARTUP_CYCLES - 1);
        end
      end
      wdr_pkg::st_hold: begin
        if (hold_cnt_reg == '0) begin
          state_next = wdr_pkg::st_run;
        end else begin
          hold_cnt_next = hold_cnt_reg - HOLD_W'(1);
        end
      end
      default: begin
        state_next = wdr_pkg::st_run;
      end
    endcase
    hold_next = (state_next == wdr_pkg::st_hold);
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      cnt_reg <= 21'h0;
      o_chip_reset <= 1'b0;
      state_reg <= wdr_pkg::st_run;
      hold_cnt_reg <= '0;
      o_startup_hold <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      o_chip_reset <= pulse_next;
      state_reg <= state_next;
      hold_cnt_reg <= hold_cnt_next;
      o_startup_hold <= hold_next;
    end
  end

  // ---------------------------------------------------------------
  // Reset-cause flags and read port
  // ---------------------------------------------------------------
  // Software clears by writing zero; a set in the same cycle wins
  always_comb begin
    cause_next = cause_reg;
    if (cause_wr) begin
      cause_next = cause_reg & i_wdata[3:0];
    end
    if (timeout) begin
      cause_next[wdr_pkg::FLD_DOG] = 1'b1;
    end
    if (brown_rise) begin
      cause_next[wdr_pkg::FLD_BROWNOUT] = 1'b1;
    end
    if (pin_rise) begin
      cause_next[wdr_pkg::FLD_PIN] = 1'b1;
    end
    rdata_next = 8'h00;
    if (i_rd) begin
      case (i_addr)
        wdr_pkg::OFS_RESET_CAUSE: rdata_next = {4'h0, cause_reg};
        wdr_pkg::OFS_CONTROL: rdata_next = {3'h0, ce_active, en_eff, sel_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Power-on reset leaves only the power-on flag set
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      cause_reg <= wdr_pkg::RST_CAUSE;
      o_rdata <= 8'h00;
    end else begin
      cause_reg <= cause_next;
      o_rdata <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  a_pulse_one_cycle: assert property (o_chip_reset |=> !o_chip_reset)
    else $error("chip reset pulse longer than one cycle");
  a_timeout_effects: assert property (timeout |=> o_chip_reset &&
    cnt_reg == 21'h0 && sel_reg == wdr_pkg::RST_SEL)
    else $error("expiry did not pulse and clear the watchdog");
  // Checked against the parameter so short bench holds pass too
  a_hold_after_pulse: assert property (o_chip_reset |=> o_startup_hold &&
    hold_cnt_reg == HOLD_W'(STARTUP_CYCLES - 1))
    else $error("start-up hold did not follow reset pulse");
  a_hold_ends: assert property (o_startup_hold && hold_cnt_reg == '0
    |=> !o_startup_hold)
    else $error("start-up hold did not end on time");
  a_hold_frozen: assert property (o_startup_hold |=> cnt_reg == 21'h0)
    else $error("counter ran during start-up hold");
  a_dog_flag_set: assert property (o_chip_reset |-> cause_reg[wdr_pkg::FLD_DOG])
    else $error("watchdog flag not set with reset pulse");
  a_dog_flag_clear: assert property (cause_wr && !timeout &&
    !i_wdata[wdr_pkg::FLD_DOG] |=> !cause_reg[wdr_pkg::FLD_DOG])
    else $error("watchdog flag not cleared by zero write");
  a_brown_flag_clear: assert property (cause_wr && !i_wdata[2] && !brown_rise
    |=> !cause_reg[wdr_pkg::FLD_BROWNOUT])
    else $error("brown-out flag not cleared by zero write");
  a_pin_flag_set: assert property (pin_rise |=> cause_reg[wdr_pkg::FLD_PIN])
    else $error("pin flag not set by pin reset");
  a_poweron_sticky: assert property ($fell(cause_reg[wdr_pkg::FLD_POWERON])
    |-> $past(cause_wr) && !$past(i_wdata[0]))
    else $error("power-on flag cleared without software write");
  a_cause_read: assert property (i_rd && i_addr == wdr_pkg::OFS_RESET_CAUSE
    |=> o_rdata == {4'h0, $past(cause_reg)})
    else $error("reset-cause read data wrong");
  a_count_step: assert property (en_eff && osc_tick && !i_kick &&
    !o_startup_hold && !chip_event |=> cnt_reg == $past(cnt_reg) + 21'h1)
    else $error("counter missed an oscillator tick");
  a_count_idle: assert property (en_eff && !osc_tick && !i_kick &&
    !o_startup_hold && !chip_event |=> $stable(cnt_reg))
    else $error("counter moved without an oscillator tick");
  a_kick_restart: assert property (i_kick |=> cnt_reg == 21'h0)
    else $error("kick did not restart counter");
  a_disabled_zero: assert property (!en_eff |=> cnt_reg == 21'h0)
    else $error("counter runs while disabled");
  a_event_clears: assert property ((pin_rise || brown_rise) |=> !en_reg &&
    sel_reg == wdr_pkg::RST_SEL && cnt_reg == 21'h0)
    else $error("chip reset did not clear the watchdog");
  a_level2_enabled: assert property (level_reg == wdr_pkg::LEVEL2 |=> en_eff)
    else $error("watchdog disabled at level 2");
  a_enable_write: assert property (ctrl_wr && i_wdata[3] && !chip_event |=> en_eff)
    else $error("enable write not accepted");
  a_timeout_locked: assert property (ctrl_wr && !ce_active && !chip_event &&
    level_reg != wdr_pkg::LEVEL0 |=> $stable(sel_reg))
    else $error("timeout changed without change-enable");
  a_change_opens: assert property (ctrl_wr && i_wdata[wdr_pkg::FLD_CHANGE] &&
    !chip_event |=> ce_cnt_reg == wdr_pkg::CE_WINDOW_CYC)
    else $error("change-enable window not opened");
  a_change_expires: assert property ($rose(ce_active) && !ctrl_wr ##1 !ctrl_wr [*3]
    |=> !ce_active)
    else $error("change-enable did not clear after four cycles");
  a_disable_guarded: assert property (ctrl_wr && !i_wdata[3] && !ce_active &&
    en_reg && !chip_event |=> en_reg)
    else $error("enable cleared without change-enable");
  a_reserved_zero: assert property (i_rd && i_addr == wdr_pkg::OFS_CONTROL
    |=> o_rdata[7:5] == 3'h0)
    else $error("reserved control bits read nonzero");
  a_level2_reads: assert property (i_rd && i_addr == wdr_pkg::OFS_CONTROL &&
    level_reg == wdr_pkg::LEVEL2 |=> o_rdata[wdr_pkg::FLD_ENABLE])
    else $error("enable bit not read as one at level 2");

  c_timeout: cover property (o_chip_reset ##1 o_startup_hold);
  c_level2_expiry: cover property (level_reg == wdr_pkg::LEVEL2 && o_chip_reset);
  c_disable_seq: cover property (en_reg && ce_active ##[1:4] !en_reg);
  c_retime: cover property (ce_active && ctrl_wr ##1 $changed(sel_reg));
  c_kick: cover property (en_eff && i_kick && cnt_reg != 21'h0);

endmodule : wdr_watchdog

// ---- sim/test_wdr_watchdog.sv ----
// Self-checking bench for the watchdog and reset-cause block.
// Drives every port itself; short period and hold parameters.
`timescale 1ns/1ps
module test_wdr_watchdog;
  localparam int PB = 8;
  localparam int SU = 5;
  localparam int LIMIT = 60000;
  logic i_mclk = 1'b0, i_reset_n = 1'b0, i_wdt_osc = 1'b0, i_kick = 1'b0;
  logic i_pin_reset = 1'b0, i_brownout = 1'b0, i_compat_fuse_n = 1'b1;
  logic i_always_on_fuse_n = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [wdr_pkg::ADDR_W-1:0] i_addr = 4'h0;
  logic [wdr_pkg::DATA_W-1:0] i_wdata = 8'h00;
  logic [wdr_pkg::DATA_W-1:0] o_rdata;
  logic o_chip_reset, o_startup_hold;
  int fail_count = 0, num_checks = 0, cyc = 0, osc_div = 0, pulses = 0;
  int m_cause, m_en, m_sel, m_lvl2, m_lvl0, m_ce_at, s, p0;

  wdr_watchdog #(.PERIOD_BASE(PB), .STARTUP_CYCLES(SU)) u_wdr_watchdog (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_wdt_osc(i_wdt_osc), .i_kick(i_kick),
    .i_pin_reset(i_pin_reset), .i_brownout(i_brownout), .i_compat_fuse_n(i_compat_fuse_n),
    .i_always_on_fuse_n(i_always_on_fuse_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_chip_reset(o_chip_reset),
    .o_startup_hold(o_startup_hold));

  // ---------------------------------------------------------------
  // Clocks and timeout
  // ---------------------------------------------------------------
  always #2.5 i_mclk = ~i_mclk;
  // Oscillator scaled to 8 mclk cycles so long periods stay short
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    osc_div <= (osc_div + 1) % 4;
    if (osc_div == 3) i_wdt_osc <= ~i_wdt_osc;
    if (o_chip_reset === 1'b1) pulses <= pulses + 1;
    if (cyc == LIMIT) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: run hung", $time);
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Compare and bus tasks
  // ---------------------------------------------------------------
  task automatic chk_reg(input string what, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_reg

  task automatic chk_cnt(input string what, input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk_cnt

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic ceok;
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    ceok = (cyc - m_ce_at) <= 4;
    if (a == 4'h0) m_cause = m_cause & d[3:0];
    else if (a == 4'h1) begin
      if (m_lvl0 || ceok) m_sel = d[2:0];
      if (d[3]) m_en = 1;
      else if (ceok && !m_lvl2) m_en = 0;
      m_ce_at = d[4] ? cyc : -100;
    end
  endtask : wr

  task automatic rd(input logic [3:0] a);
    logic [7:0] exp;
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    exp = 8'h00;
    if (a == 4'h0) exp = m_cause[7:0];
    if (a == 4'h1) exp = {3'h0, (cyc - m_ce_at) <= 4, m_en[0], m_sel[2:0]};
    #1;
    chk_reg("read data", o_rdata, exp);
  endtask : rd

  task automatic chip_event(input int pin);
    @(posedge i_mclk);
    if (pin) i_pin_reset <= 1'b1;
    else i_brownout <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_pin_reset <= 1'b0;
    i_brownout <= 1'b0;
    repeat (6) @(posedge i_mclk);
    m_cause = m_cause | (pin ? 2 : 4);
    m_en = m_lvl2;
    m_sel = 0;
    m_ce_at = -100;
  endtask : chip_event

  task automatic do_reset(input logic cf_n, input logic ao_n);
    @(posedge i_mclk);
    i_compat_fuse_n <= cf_n;
    i_always_on_fuse_n <= ao_n;
    i_reset_n <= 1'b0;
    repeat (10) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    m_lvl2 = !ao_n;
    m_lvl0 = ao_n && !cf_n;
    m_cause = 1;
    m_en = m_lvl2;
    m_sel = 0;
    m_ce_at = -100;
  endtask : do_reset

  // Kick mid low phase, far from any oscillator tick
  task automatic kick();
    @(negedge i_wdt_osc);
    @(posedge i_mclk);
    i_kick <= 1'b1;
    @(posedge i_mclk);
    i_kick <= 1'b0;
  endtask : kick

  task automatic expire(input int sel);
    int ticks, hold, n;
    logic prev;
    kick();
    ticks = 0;
    n = 0;
    prev = i_wdt_osc;
    while (o_chip_reset !== 1'b1 && n < 20000) begin
      @(posedge i_mclk);
      #1;
      if (i_wdt_osc && !prev) ticks++;
      prev = i_wdt_osc;
      n++;
    end
    chk_cnt("ticks to expiry", ticks, PB << sel);
    @(posedge i_mclk);
    #1;
    chk_reg("pulse then hold", {6'h00, o_chip_reset, o_startup_hold}, 8'h01);
    hold = 0;
    while (o_startup_hold === 1'b1 && hold < 100) begin
      @(posedge i_mclk);
      #1;
      hold++;
    end
    chk_cnt("hold length", hold, SU);
    m_cause = m_cause | 8;
    m_en = m_lvl2;
    m_sel = 0;
    m_ce_at = -100;
  endtask : expire

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(15));
    m_ce_at = -100;
    do_reset(1'b1, 1'b1);
    rd(4'h0);
    rd(4'h1);
    rd(4'h5);
    wr(4'h0, 8'h00);
    rd(4'h0);
    wr(4'h1, 8'hEF);
    rd(4'h1);
    wr(4'h1, 8'h00);
    rd(4'h1);
    wr(4'h1, 8'h18);
    rd(4'h1);
    wr(4'h1, 8'h18);
    wr(4'h1, 8'h03);
    rd(4'h1);
    wr(4'h1, 8'h08);
    wr(4'h1, 8'h18);
    repeat (6) @(posedge i_mclk);
    wr(4'h1, 8'h00);
    rd(4'h1);
    $display("test level one control done");
    chip_event(1);
    rd(4'h0);
    rd(4'h1);
    chip_event(0);
    rd(4'h0);
    wr(4'h0, 8'hFF);
    rd(4'h0);
    wr(4'h0, 8'h00);
    rd(4'h0);
    s = $urandom % 4;
    wr(4'h1, 8'h18);
    wr(4'h1, 8'h08 | s[7:0]);
    expire(s);
    rd(4'h0);
    rd(4'h1);
    $display("test flags and expiry done");
    do_reset(1'b0, 1'b1);
    wr(4'h1, 8'h08);
    p0 = pulses;
    repeat (10) begin
      kick();
      repeat (8 * ($urandom % 5)) @(posedge i_mclk);
    end
    chk_cnt("pulses while kicked", pulses, p0);
    for (int k = 0; k < 8; k++) begin
      wr(4'h1, 8'h08 | k[7:0]);
      rd(4'h1);
      expire(k);
    end
    $display("test level zero periods done");
    do_reset(1'b1, 1'b0);
    rd(4'h1);
    wr(4'h1, 8'h18);
    wr(4'h1, 8'h00);
    rd(4'h1);
    wr(4'h1, 8'h18);
    wr(4'h1, 8'h02);
    rd(4'h1);
    expire(2);
    rd(4'h0);
    $display("test level two done");
    give_verdict();
  end
endmodule : test_wdr_watchdog
